/* rtl/slbc_top.sv */
// Strap latch boot configuration: captures five strap pins at the
// release of a system reset and offers them to boot logic and software.
// Assumes pins are asynchronous, and sys_resetn is the system reset
// (power-on, RTC watchdog, brownout), separate from the APB reset.
// Assumes clk_en low freezes every flop, the synchronisers included.
// The hold time is counted in pclk cycles, so HOLD_CYCLES must be
// scaled if pclk runs at another rate than the one it was set for.
// A host must keep the straps still until pins_functional rises,
// since the latches sample at the end of the hold window and not at
// the release edge itself.
// Behaviour
// - Five strap input pins are captured.
// - Software reads all five captured bits.
// - Capture pin levels at system reset release.
// - Captured bits stay until the next release of enable or system reset; a bus reset (presetn) reloads them with the pull levels.
// - Pulls enabled on strap pins during reset.
// - Pins return to normal use after release.
// - Supply strap 0 selects 3.3V, 1 1.8V.
// - Boot strap 1 flash; both 0 download.
// - Two straps choose SD sample/output edges.
// - Firmware may override supply and edge timing.
// - Supply strap is pulled high on module.
// - Module enable input is active high.
`timescale 1ns/1ps
`include "slbc_consts.svh"
module slbc_top #(
    parameter int HOLD_CYCLES = (`SLBC_HOLD_MS * `SLBC_CLK_KHZ)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sys_resetn,
    input wire logic chip_power_up_input,
    input wire logic clk_en,
    input wire logic [`SLBC_NUM_STRAPS-1:0] strap_pins,
    output logic [`SLBC_NUM_STRAPS-1:0] pull_enable,
    output logic [`SLBC_NUM_STRAPS-1:0] pull_up,
    output logic pins_functional,
    output logic log_to_console_transmit_pin,
    output logic flash_supply_1v8,
    output slbc_pkg::slbc_boot_t boot_mode,
    output slbc_pkg::slbc_sd_edge_t sd_edge,
    output logic boot_ready,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import slbc_pkg::*;

    localparam logic [`SLBC_NUM_STRAPS-1:0] PULL_DIR = `SLBC_PULL_DIR;
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

    logic [`SLBC_NUM_STRAPS-1:0] pins_sync;
    logic en_sync;
    logic rst_sync;
    logic rst_seen_reg;
    slbc_state_t state_reg;
    slbc_state_t state_next;
    logic [CW-1:0] hold_cnt_reg;
    slbc_straps_t straps_reg;
    logic [3:0] ctrl_reg;
    slbc_boot_t dec_boot;
    logic dec_1v8;
    logic dec_log;
    slbc_sd_edge_t dec_edge;
    logic active;
    logic apb_wr;
    logic apb_rd;
    logic [1:0] edge_ovr_reg;
    logic hit_strap;
    logic hit_ctrl;
    logic hit_stat;
    logic [31:0] rdata_next;

    // Strap pins cross into pclk through two flip-flops each.
    genvar gi;
    generate
        for (gi = 0; gi < `SLBC_NUM_STRAPS; gi++) begin : g_sync
            slbc_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .async_in(strap_pins[gi]),
                .sync_out(pins_sync[gi])
            );
        end
    endgenerate

    // Enable and system reset are pins as well and are synchronised.
    slbc_sync u_en_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(chip_power_up_input),
        .sync_out(en_sync)
    );

    slbc_sync u_rst_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(sys_resetn),
        .sync_out(rst_sync)
    );

    // The block is active only while the enable pin and the system reset are both high.
    assign active = en_sync & rst_sync;

    // A drop of the enable or the system reset is remembered so that
    // only a fresh release of either starts a capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen_reg <= 1'b1;
        end else if (clk_en) begin
            if (!active) begin
                rst_seen_reg <= 1'b1;
            end else if (state_reg == SLBC_ST_RUN) begin
                rst_seen_reg <= 1'b0;
            end
        end
    end

    // Reset holds pulls on; release waits the hold time then captures.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SLBC_ST_RESET: begin
                if (active && rst_seen_reg) begin
                    state_next = SLBC_ST_HOLD;
                end
            end
            SLBC_ST_HOLD: begin
                if (!active) begin
                    state_next = SLBC_ST_RESET;
                end else if (hold_cnt_reg == HOLD_LAST) begin
                    state_next = SLBC_ST_RUN;
                end
            end
            SLBC_ST_RUN: begin
                if (!active) begin
                    state_next = SLBC_ST_RESET;
                end
            end
            default: begin
                state_next = SLBC_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SLBC_ST_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Hold counter spans the pin hold time after enable and system reset are both high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_reg <= '0;
        end else if (clk_en) begin
            if (state_reg == SLBC_ST_HOLD) begin
                hold_cnt_reg <= hold_cnt_reg + CW'(1);
            end else begin
                hold_cnt_reg <= '0;
            end
        end
    end

    // Capture happens once, on the step into run; only the bus reset
    // also writes the latches, loading the pull levels; software cannot. The
    // pins were held through the whole hold window, so the synchronised
    // copy has settled long before it is sampled here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_reg <= slbc_straps_t'(PULL_DIR);
        end else if (clk_en) begin
            if (state_reg == SLBC_ST_HOLD
                && state_next == SLBC_ST_RUN) begin
                straps_reg <= slbc_straps_t'(pins_sync);
            end
        end
    end

    // Pull controls follow the next state, so they change on the same
    // edge as the state register and reach the pads glitch free. The
    // pulls stay on until the latches hold their values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_enable <= '1;
        end else if (clk_en) begin
            pull_enable <= (state_next == SLBC_ST_RUN) ? '0 : '1;
        end
    end

    // The pins go back to ordinary use only once the latches are
    // loaded; before that a host may still be driving them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_functional <= 1'b0;
        end else if (clk_en) begin
            pins_functional <= (state_next == SLBC_ST_RUN);
        end
    end

    // Boot logic waits on this flag; it rises with the run flag, one
    // cycle before the decoded settings have left their flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_ready <= 1'b0;
        end else if (clk_en) begin
            boot_ready <= (state_next == SLBC_ST_RUN);
        end
    end

    // The supply pull points up on this module, so an open supply pin
    // selects 1.8 V, which the attached memories need.
    assign pull_up = PULL_DIR;

    // Decoding is kept apart so that the strap tables can be checked
    // on their own, without the capture sequence around them.
    slbc_decode u_decode (
        .straps(straps_reg),
        .boot_mode(dec_boot),
        .flash_1v8(dec_1v8),
        .log_enable(dec_log),
        .sd_edge(dec_edge)
    );

    // Address decode; every transfer is answered in its first access
    // cycle, so the master never waits.
    assign hit_strap = (paddr == `SLBC_OFF_STRAP);
    assign hit_ctrl = (paddr == `SLBC_OFF_CTRL);
    assign hit_stat = (paddr == `SLBC_OFF_STAT);
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    assign pready = 1'b1;

    // Unmapped reads and writes to anything but control are refused;
    // a refused write changes nothing, since only control is writable.
    // The error stands only in the access cycle.
    assign pslverr = (apb_rd & ~(hit_strap | hit_ctrl | hit_stat))
        | (apb_wr & ~hit_ctrl);

    // Control flags: supply override enable and value, edge override
    // enable and one spare bit. A bus reset clears them, so the straps
    // decide again until firmware writes anew.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 4'h0;
        end else if (clk_en && apb_wr && hit_ctrl) begin
            ctrl_reg <= pwdata[`SLBC_CTRL_FLAGS_MSB:0];
        end
    end

    // Edge values used while the edge override is on, {sample, output}.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_ovr_reg <= 2'h0;
        end else if (clk_en && apb_wr && hit_ctrl) begin
            edge_ovr_reg <= pwdata[`SLBC_CTRL_EDGE_MSB:`SLBC_CTRL_EDGE_LSB];
        end
    end

    // Supply level: a firmware override wins over the captured strap.
    // Outputs come from flip-flops so boot logic sees stable levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_supply_1v8 <= 1'b0;
        end else if (clk_en) begin
            if (ctrl_reg[`SLBC_CTRL_SUP_OVR]) begin
                flash_supply_1v8 <= ctrl_reg[`SLBC_CTRL_SUP_VAL];
            end else begin
                flash_supply_1v8 <= dec_1v8;
            end
        end
    end

    // Boot source follows the captured straps only; no override exists.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_mode <= SLBC_BOOT_NONE;
        end else if (clk_en) begin
            boot_mode <= dec_boot;
        end
    end

    // The console log flag cannot be overridden, as boot is long over
    // by the time firmware could write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_to_console_transmit_pin <= 1'b0;
        end else if (clk_en) begin
            log_to_console_transmit_pin <= dec_log;
        end
    end

    // Slave SD edges: an override replaces both edges at once, so a
    // half-written pair never reaches the interface.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_edge <= '0;
        end else if (clk_en) begin
            if (ctrl_reg[`SLBC_CTRL_EDGE_OVR]) begin
                sd_edge <= slbc_sd_edge_t'(edge_ovr_reg);
            end else begin
                sd_edge <= dec_edge;
            end
        end
    end

    // Read data for the addressed register. An unmapped address reads
    // as zero, and pslverr tells the master why.
    always_comb begin
        rdata_next = 32'h00000000;
        if (hit_strap) begin
            rdata_next = {27'h0, straps_reg};
        end else if (hit_ctrl) begin
            rdata_next = {26'h0, edge_ovr_reg, ctrl_reg};
        end else if (hit_stat) begin
            rdata_next = {26'h0, dec_edge, dec_boot,
                          pins_functional, active};
        end
    end

    // Read data is registered at setup and taken in the access cycle;
    // it stands until the next read setup. Loading it in setup costs a
    // flop stage but keeps pready tied high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end
endmodule

/* rtl/slbc_consts.svh */
// Constants for the strap latch boot configuration block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SLBC_CONSTS_SVH
`define SLBC_CONSTS_SVH
`define SLBC_NUM_STRAPS 5
`define SLBC_BIT_SUPPLY 0
`define SLBC_BIT_BOOT 1
`define SLBC_BIT_QUAL 2
`define SLBC_BIT_LOG 3
`define SLBC_BIT_OEDGE 4
`define SLBC_PULL_DIR 5'h1B
`define SLBC_OFF_STRAP 12'h000
`define SLBC_OFF_CTRL 12'h004
`define SLBC_OFF_STAT 12'h008
`define SLBC_CTRL_MASK 32'h0000000F
`define SLBC_CTRL_SUP_OVR 0
`define SLBC_CTRL_SUP_VAL 1
`define SLBC_CTRL_EDGE_OVR 2
`define SLBC_CTRL_FLAGS_MSB 3
`define SLBC_CTRL_EDGE_LSB 4
`define SLBC_CTRL_EDGE_MSB 5
`define SLBC_HOLD_MS 1
`define SLBC_CLK_KHZ 200000
`endif

/* rtl/slbc_pkg.sv */
// Types for the strap latch boot configuration block.
// Assumes slbc_consts.svh is visible on the include path.
package slbc_pkg;
    typedef struct packed {
        logic output_edge_strap;
        logic log_and_sample_edge_strap;
        logic download_qualifier_strap;
        logic boot_select_strap;
        logic supply_select_strap;
    } slbc_straps_t;

    typedef enum logic [1:0] {
        SLBC_BOOT_NONE = 2'h0,
        SLBC_BOOT_FLASH = 2'h1,
        SLBC_BOOT_DOWNLOAD = 2'h2
    } slbc_boot_t;

    typedef struct packed {
        logic sample_rising;
        logic output_rising;
    } slbc_sd_edge_t;

    typedef enum logic [1:0] {
        SLBC_ST_RESET = 2'b00,
        SLBC_ST_HOLD = 2'b01,
        SLBC_ST_RUN = 2'b11
    } slbc_state_t;
endpackage

/* rtl/slbc_sync.sv */
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
module slbc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // The first stage feeds only the second, to contain metastability.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* rtl/slbc_decode.sv */
// Decodes captured straps into boot settings.
// Assumes straps come from latches that are stable after capture.
`timescale 1ns/1ps
`include "slbc_consts.svh"
module slbc_decode (
    input slbc_pkg::slbc_straps_t straps,
    output slbc_pkg::slbc_boot_t boot_mode,
    output logic flash_1v8,
    output logic log_enable,
    output slbc_pkg::slbc_sd_edge_t sd_edge
);
    import slbc_pkg::*;

    // Boot select high wins; the qualifier only matters when it is low.
    always_comb begin
        if (straps.boot_select_strap) begin
            boot_mode = SLBC_BOOT_FLASH;
        end else if (!straps.download_qualifier_strap) begin
            boot_mode = SLBC_BOOT_DOWNLOAD;
        end else begin
            boot_mode = SLBC_BOOT_NONE;
        end
    end

    // Supply, log and edge settings map straight from the strap bits.
    assign flash_1v8 = straps.supply_select_strap;
    assign log_enable = straps.log_and_sample_edge_strap;
    assign sd_edge.sample_rising = straps.log_and_sample_edge_strap;
    assign sd_edge.output_rising = straps.output_edge_strap;
endmodule

/* verification/slbc_host_pins.sv */
// Board side of the strap pins: a host driving levels through reset.
// Assumes the chip's pull controls come straight from the top module.
`timescale 1ns/1ps
module slbc_host_pins (
    input wire logic pclk,
    input wire logic drive_en,
    input wire logic [4:0] drive_val,
    input wire logic [4:0] pull_enable,
    input wire logic [4:0] pull_up,
    input wire logic pins_functional,
    output logic [4:0] strap_pins
);
    logic held_reg = 1'h0;
    logic [4:0] float_reg = 5'h15;
    // The host lets go as soon as it sees the pins back in normal use.
    always_ff @(posedge pclk) begin
        held_reg <= drive_en && !pins_functional;
        float_reg <= ~float_reg;
    end
    // A floating line toggles, so a late capture cannot pass by luck.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (held_reg) strap_pins[i] = drive_val[i];
            else if (pull_enable[i]) strap_pins[i] = pull_up[i];
            else strap_pins[i] = float_reg[i];
        end
    end
endmodule

/* verification/slbc_top_chk.sv */
// Checker for the strap latch block, watching the top ports only.
// Assumes the strap pins hold still until the pins go functional.
`timescale 1ns/1ps
`include "slbc_consts.svh"
module slbc_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic chip_power_up_input,
    input wire logic clk_en,
    input wire logic [4:0] strap_pins,
    input wire logic [4:0] pull_enable,
    input wire logic pins_functional,
    input wire logic log_to_console_transmit_pin,
    input wire logic flash_supply_1v8,
    input wire slbc_pkg::slbc_boot_t boot_mode,
    input wire slbc_pkg::slbc_sd_edge_t sd_edge,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    import slbc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pulls are on exactly while the pins are not yet in normal use.
    property p_pull; pull_enable == {5{!pins_functional}}; endproperty
    a_pull: assert property (p_pull) else $error("pull enable");
    property p_ro;
        psel && penable && pwrite && paddr != `SLBC_OFF_CTRL |-> pslverr;
    endproperty
    a_ro: assert property (p_ro) else $error("write not refused");
    property p_rd;
        psel && penable && !pwrite && paddr == `SLBC_OFF_STRAP &&
        pins_functional && $past(pins_functional, 3)
        |-> prdata[3] == log_to_console_transmit_pin;
    endproperty
    a_rd: assert property (p_rd) else $error("strap read");
    property p_log; $rose(pins_functional)
        |-> ##2 log_to_console_transmit_pin == $past(strap_pins[3], 5);
    endproperty
    a_log: assert property (p_log) else $error("log capture");
    property p_boot; $rose(pins_functional) |->
        ##2 (boot_mode == SLBC_BOOT_FLASH) == $past(strap_pins[1], 5);
    endproperty
    a_boot: assert property (p_boot) else $error("boot decode");
    property p_sd; $rose(pins_functional) |-> ##2
        sd_edge == {$past(strap_pins[3], 5), $past(strap_pins[4], 5)};
    endproperty
    a_sd: assert property (p_sd) else $error("sd edge decode");
    property p_sup; $rose(pins_functional)
        |-> ##2 flash_supply_1v8 == $past(strap_pins[0], 5);
    endproperty
    a_sup: assert property (p_sup) else $error("supply decode");
    property p_keep; pins_functional && $past(pins_functional, 3)
        |-> $stable(boot_mode) && $stable(log_to_console_transmit_pin);
    endproperty
    a_keep: assert property (p_keep) else $error("straps changed");
    property p_en;
        (clk_en && !chip_power_up_input) [*5] |-> !pins_functional;
    endproperty
    a_en: assert property (p_en) else $error("enable ignored");
    c_cap: cover property ($rose(pins_functional));
    c_err: cover property (psel && penable && pslverr);
    c_drop: cover property ($fell(pins_functional));
endmodule
bind slbc_top slbc_top_chk u_chk (.pclk, .presetn, .chip_power_up_input,
    .clk_en, .strap_pins, .pull_enable, .pins_functional,
    .log_to_console_transmit_pin, .flash_supply_1v8, .boot_mode,
    .sd_edge, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr);

/* verification/strap_latch_boot_config_tb.sv */
// Self-checking bench for the strap latch boot configuration block.
// Assumes a short hold count and the host pin model beside the design.
`timescale 1ns/1ps
`include "slbc_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module strap_latch_boot_config_tb;
    import slbc_pkg::*;
    logic pclk = 0, presetn = 0, sys_resetn = 0, clk_en = 1;
    logic chip_power_up_input = 1, drive_en = 0, boot_ready;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [4:0] drive_val = 0, strap_pins, pull_enable, pull_up, pv;
    logic pins_functional, log_o, sup_o, ev, el;
    logic [1:0] eb, es;
    slbc_boot_t boot_mode;
    slbc_sd_edge_t sd_edge;
    int n_mismatch = 0, n_compared = 0;
    // Rows: {pins, boot mode, 1.8 V, log, {sample, output} edge}.
    logic [10:0] rows [4] = '{11'h020, 11'h4D9, 11'h396, 11'h707};
    slbc_top #(.HOLD_CYCLES(4)) u_dut (.pclk, .presetn, .sys_resetn,
        .chip_power_up_input, .clk_en, .strap_pins, .pull_enable,
        .pull_up, .pins_functional, .log_to_console_transmit_pin(log_o),
        .flash_supply_1v8(sup_o), .boot_mode, .sd_edge, .boot_ready,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    slbc_host_pins u_host (.pclk, .drive_en, .drive_val, .pull_enable,
        .pull_up, .pins_functional, .strap_pins);
    always #2.5 pclk = ~pclk;
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wt(input logic v);
        for (int k = 0; k < 200 && pins_functional !== v; k++) @(posedge pclk);
        `CHK("functional", v, pins_functional)
    endtask
    // System reset pulse; the host model holds the pins meanwhile when de is set.
    task automatic cap(input logic de, input logic [4:0] v);
        drive_en <= de;
        drive_val <= v;
        sys_resetn <= 1'h0;
        repeat (4) @(posedge pclk);
        sys_resetn <= 1'h1;
        wt(1'h1);
        repeat (10) @(posedge pclk);
        apb(1'h0, `SLBC_OFF_STRAP, 32'h0);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            {pv, eb, ev, el, es} = rows[i];
            cap(1'h1, pv);
            `CHK("strap reg", pv, rd[4:0])
            `CHK("boot", eb, boot_mode)
            `CHK("supply", ev, sup_o)
            `CHK("log", el, log_o)
            `CHK("sd edge", es, sd_edge)
        end
        cap(1'h0, 5'h00);
        `CHK("pulled", 5'h1B, rd[4:0])
        `CHK("ready", 1'h1, boot_ready)
        apb(1'h1, `SLBC_OFF_CTRL, 32'h00000005);
        repeat (3) @(posedge pclk);
        `CHK("supply ovr", 1'h0, sup_o)
        `CHK("edge ovr", 2'h0, sd_edge)
        apb(1'h0, `SLBC_OFF_CTRL, 32'h0);
        `CHK("ctrl read", 32'h00000005, rd)
        apb(1'h1, `SLBC_OFF_CTRL, 32'h0);
        apb(1'h1, `SLBC_OFF_STRAP, 32'h1F);
        `CHK("ro write", 1'h1, er)
        apb(1'h0, 12'h00C, 32'h0);
        `CHK("unmapped", 1'h1, er)
        apb(1'h0, `SLBC_OFF_STAT, 32'h0);
        `CHK("status", 6'h37, rd[5:0])
        chip_power_up_input <= 1'h0;
        wt(1'h0);
        `CHK("pulls on", 5'h1F, pull_enable)
        chip_power_up_input <= 1'h1;
        wt(1'h1);
        report_and_stop;
    end
endmodule
